//--- logic/can_cmd_pkg.sv
package can_cmd_pkg;
    // ascii codes of the command set
    localparam logic [7:0] CH_CR     = 8'h0D;
    localparam logic [7:0] CH_BELL   = 8'h07;
    localparam logic [7:0] CH_ACK    = 8'h7A;
    localparam logic [7:0] CH_OPEN   = 8'h4F;
    localparam logic [7:0] CH_LISTEN = 8'h4C;
    localparam logic [7:0] CH_LOOP   = 8'h59;
    localparam logic [7:0] CH_CLOSE  = 8'h43;
    localparam logic [7:0] CH_RATE   = 8'h53;
    localparam logic [7:0] CH_SEND   = 8'h74;
    localparam logic [7:0] CH_ZERO   = 8'h30;
    localparam logic [7:0] CH_EIGHT  = 8'h38;

    // bitrate selectors: 6 is 500 kbit/s, 8 the highest
    localparam logic [3:0] RATE_500K  = 4'h6;
    localparam logic [3:0] RATE_RESET = RATE_500K;
    localparam logic [3:0] DLC_MAX    = 4'h8;

    // send line: three id digits, one length digit, then data pairs
    localparam logic [4:0] SEND_HDR  = 5'h04;
    localparam logic [4:0] POS_MAX   = 5'h1F;

    // lamp timing
    localparam longint     CLK_HZ         = 20_000_000;
    localparam longint     FLASH_HALF_MS  = 125;
    localparam longint     FLASH_HALF_CYC = FLASH_HALF_MS * CLK_HZ / 1000;
    localparam logic [2:0] INIT_TOGGLES   = 3'h7;
    localparam logic [2:0] ACT_HOLD       = 3'h4;

    typedef struct packed {
        logic open;
        logic listen;
        logic loopback;
    } chan_t;

    typedef struct packed {
        logic [10:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } can_frame_t;
endpackage

//--- logic/reply_fifo.sv
`timescale 1ns/1ns
module reply_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_t;

    fifo_t st;
    fifo_t next_st;
    logic  push;
    logic  pop;

    assign in_ready_out  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (st.cnt != '0);
    assign out_data_out  = st.mem[st.rd];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_in;
            next_st.wr         = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

//--- logic/serial_can_command_led_ctrl.sv
`timescale 1ns/1ns
module serial_can_command_led_ctrl
    import can_cmd_pkg::*;
#(
    parameter int FLASH_HALF = int'(can_cmd_pkg::FLASH_HALF_CYC),
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                    clk_in,
    input  wire logic                    nrst_in,
    input  wire logic                    rx_valid_in,
    output logic                         rx_ready_out,
    input  wire logic [7:0]              rx_data_in,
    output logic                         tx_valid_out,
    input  wire logic                    tx_ready_in,
    output logic [7:0]                   tx_data_out,
    output logic                         frame_valid_out,
    input  wire logic                    frame_ready_in,
    output can_cmd_pkg::can_frame_t      frame_out,
    output can_cmd_pkg::chan_t           chan_out,
    output logic [3:0]                   bitrate_out,
    input  wire logic                    frame_event_in,
    input  wire logic                    can_error_in,
    output logic                         power_led_out,
    output logic                         act_led_out,
    output logic                         err_led_out
);
    import can_cmd_pkg::*;

    localparam int DW = $clog2(FLASH_HALF + 1);

    typedef enum logic [2:0] {M_INIT, M_IDLE, M_LINE, M_SEND, M_REPLY} mode_t;

    typedef struct packed {
        mode_t       mode;
        logic        pwr;
        logic [DW-1:0] div;
        logic        phase;
        logic [2:0]  flashes;
        logic [2:0]  act;
        logic [7:0]  cmd;
        logic [4:0]  pos;
        logic        err;
        logic [10:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
        chan_t       chan;
        logic [3:0]  rate;
        logic [1:0]  rep_n;
        logic [7:0]  rep0;
        logic [7:0]  rep1;
    } state_t;

    state_t     st;
    state_t     next_st;
    logic       tick;
    logic       fifo_ready;
    logic       fifo_valid;
    logic [7:0] fifo_data;
    logic [4:0] nib;
    logic       ok;
    logic [4:0] send_len;

    function automatic logic [4:0] hex_nib(input logic [7:0] c);
        hex_nib = 5'h00;
        if (c >= 8'h30 && c <= 8'h39) begin
            hex_nib = {1'b1, c[3:0]};
        end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
            hex_nib = {1'b1, c[3:0] + 4'h9};
        end
    endfunction

    assign tick     = (st.div == DW'(FLASH_HALF - 1));
    assign nib      = hex_nib(rx_data_in);
    assign send_len = SEND_HDR + {st.dlc, 1'b0};

    always_comb begin
        next_st     = st;
        ok          = 1'b0;
        next_st.pwr = 1'b1;
        next_st.div = tick ? '0 : st.div + 1'b1;
        if (tick) begin
            next_st.phase = ~st.phase;
        end
        if (tick && st.act != 3'h0) begin
            next_st.act = st.act - 3'h1;
        end
        if (frame_event_in) begin
            next_st.act = ACT_HOLD;
        end
        unique case (st.mode)
            M_INIT: begin
                if (tick) begin
                    if (st.flashes == INIT_TOGGLES) begin
                        next_st.mode = M_IDLE;
                    end else begin
                        next_st.flashes = st.flashes + 3'h1;
                    end
                end
            end
            M_IDLE: begin
                if (rx_valid_in) begin
                    next_st.cmd  = rx_data_in;
                    next_st.pos  = '0;
                    next_st.err  = 1'b0;
                    next_st.id   = '0;
                    next_st.dlc  = '0;
                    next_st.data = '0;
                    next_st.mode = M_LINE;
                    if (rx_data_in == CH_CR) begin
                        next_st.mode  = M_REPLY;
                        next_st.rep_n = 2'h1;
                        next_st.rep1  = CH_BELL;
                    end
                end
            end
            M_LINE: begin
                if (rx_valid_in && rx_data_in != CH_CR) begin
                    if (st.pos != POS_MAX) begin
                        next_st.pos = st.pos + 5'h1;
                    end
                    unique case (st.cmd)
                        CH_RATE: begin
                            next_st.dlc = rx_data_in[3:0];
                            if (st.pos != 5'h0 || rx_data_in < CH_ZERO
                                || rx_data_in > CH_EIGHT) begin
                                next_st.err = 1'b1;
                            end
                        end
                        CH_SEND: begin
                            if (!nib[4]) begin
                                next_st.err = 1'b1;
                            end else if (st.pos < 5'h3) begin
                                next_st.id = {st.id[6:0], nib[3:0]};
                                if (st.pos == 5'h0 && nib[3]) begin
                                    next_st.err = 1'b1;
                                end
                            end else if (st.pos == 5'h3) begin
                                next_st.dlc = nib[3:0];
                                if (nib[3:0] > DLC_MAX) begin
                                    next_st.err = 1'b1;
                                end
                            end else if (st.pos >= send_len) begin
                                next_st.err = 1'b1;
                            end else begin
                                next_st.data = {st.data[59:0], nib[3:0]};
                            end
                        end
                        default: next_st.err = 1'b1;
                    endcase
                end else if (rx_valid_in) begin
                    next_st.mode  = M_REPLY;
                    next_st.rep_n = 2'h1;
                    next_st.rep1  = CH_CR;
                    unique case (st.cmd)
                        CH_OPEN, CH_LISTEN, CH_LOOP: begin
                            ok = st.pos == 5'h0 && !st.chan.open;
                            if (ok) begin
                                next_st.chan.open     = 1'b1;
                                next_st.chan.listen   = st.cmd == CH_LISTEN;
                                next_st.chan.loopback = st.cmd == CH_LOOP;
                            end
                        end
                        CH_CLOSE: begin
                            ok = st.pos == 5'h0 && st.chan.open;
                            if (ok) begin
                                next_st.chan = '0;
                            end
                        end
                        CH_RATE: begin
                            ok = st.pos == 5'h1 && !st.err && !st.chan.open;
                            if (ok) begin
                                next_st.rate = st.dlc;
                            end
                        end
                        CH_SEND: begin
                            // listen-only never puts a frame on the bus
                            ok = st.pos == send_len && !st.err && st.chan.open
                                && !st.chan.listen;
                            if (ok) begin
                                next_st.mode = M_SEND;
                                next_st.data = st.data << {DLC_MAX - st.dlc, 3'b000};
                            end
                        end
                        default: ok = 1'b0;
                    endcase
                    if (!ok) begin
                        next_st.rep1 = CH_BELL;
                    end
                end
            end
            M_SEND: begin
                if (frame_ready_in) begin
                    next_st.mode  = M_REPLY;
                    next_st.rep_n = 2'h2;
                    next_st.rep0  = CH_ACK;
                    next_st.rep1  = CH_CR;
                end
            end
            M_REPLY: begin
                // a full reply queue stalls here, and with it the receiver
                if (fifo_ready) begin
                    next_st.rep_n = st.rep_n - 2'h1;
                    if (st.rep_n == 2'h1) begin
                        next_st.mode = M_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st      <= '0;
            st.mode <= M_INIT;
            st.rate <= RATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rx_ready_out    = (st.mode == M_IDLE) || (st.mode == M_LINE);
    assign fifo_valid      = (st.mode == M_REPLY);
    assign fifo_data       = (st.rep_n == 2'h2) ? st.rep0 : st.rep1;
    assign frame_valid_out = (st.mode == M_SEND);
    assign frame_out       = '{id: st.id, dlc: st.dlc, data: st.data};
    assign chan_out        = st.chan;
    assign bitrate_out     = st.rate;
    assign power_led_out   = st.pwr;
    // traffic flashing takes precedence over the steady open indication
    assign act_led_out     = (st.mode == M_INIT) ? st.phase :
                             (st.act != 3'h0) ? st.phase : st.chan.open;
    assign err_led_out     = (st.mode == M_INIT) ? st.phase : can_error_in && st.phase;

    reply_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_reply_fifo (
        .clk_in        (clk_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (fifo_valid),
        .in_ready_out  (fifo_ready),
        .in_data_in    (fifo_data),
        .out_valid_out (tx_valid_out),
        .out_ready_in  (tx_ready_in),
        .out_data_out  (tx_data_out)
    );

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    init_lamps_a: assert property ((st.mode == M_INIT) |-> act_led_out == err_led_out)
        else $error("init lamps not flashing together");
    init_end_a: assert property ((st.mode == M_INIT && tick && st.flashes == INIT_TOGGLES)
        |=> st.mode == M_IDLE && !act_led_out && power_led_out)
        else $error("init did not end after four flashes");
    open_lamp_a: assert property ((st.mode != M_INIT && st.act == 3'h0 && st.chan.open)
        |-> act_led_out)
        else $error("activity lamp dark on open channel");
    closed_lamp_a: assert property ((st.mode != M_INIT && st.act == 3'h0 && !st.chan.open)
        |-> !act_led_out)
        else $error("activity lamp lit on closed channel");
    traffic_hold_a: assert property (frame_event_in |=> st.act == ACT_HOLD)
        else $error("traffic did not restart flashing");
    // the error input may drop right after a tick, which ends the flashing legally
    error_flash_a: assert property (
        (st.mode != M_INIT && tick && can_error_in && $past(can_error_in))
        |=> !can_error_in || err_led_out != $past(err_led_out))
        else $error("error lamp not flashing");
    rate_closed_a: assert property ((bitrate_out != $past(bitrate_out))
        |-> !chan_out.open && $past(st.mode) == M_LINE)
        else $error("bitrate changed while open");
    rate_six_a: assert property ((st.mode == M_LINE && rx_valid_in && rx_data_in == CH_CR
        && st.cmd == CH_RATE && st.pos == 5'h1 && !st.err && !st.chan.open
        && st.dlc == RATE_500K) |=> bitrate_out == RATE_500K && fifo_data == CH_CR)
        else $error("S6 not applied");
    open_reply_a: assert property (
        $rose(chan_out.open) |-> fifo_valid && fifo_data == CH_CR
        && chan_out.listen == ($past(st.cmd) == CH_LISTEN))
        else $error("open without proper reply");
    // a full queue may hold the acknowledge letter back, and may free up meanwhile
    send_ack_a: assert property (
        (frame_valid_out && frame_ready_in) |=> fifo_valid && fifo_data == CH_ACK
        ##1 fifo_valid && (fifo_data == CH_CR || !$past(fifo_ready)))
        else $error("send reply wrong");
    close_a: assert property ($fell(chan_out.open) |-> !chan_out.loopback
        && $past(st.cmd) == CH_CLOSE)
        else $error("channel closed by wrong command");
    bell_a: assert property ((st.mode == M_LINE && rx_valid_in && rx_data_in == CH_CR
        && st.err) |=> fifo_valid && fifo_data == CH_BELL)
        else $error("bad line not answered with bell");
    listen_tx_a: assert property (frame_valid_out |-> chan_out.open && !chan_out.listen)
        else $error("transmit in listen-only");
    loop_mode_a: assert property (chan_out.loopback |-> chan_out.open && !chan_out.listen)
        else $error("loopback flag without open channel");

    init_done_c: cover property (st.mode == M_INIT ##1 st.mode == M_IDLE);
    frame_sent_c: cover property (frame_valid_out && frame_ready_in);
    bell_sent_c: cover property (fifo_valid && fifo_ready && fifo_data == CH_BELL);
    fifo_full_c: cover property (fifo_valid && !fifo_ready);
endmodule

//--- verif/host_sink.sv
`timescale 1ns/1ns
module host_sink (
    input  wire logic       clk_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       hold_in,
    input  wire logic       slow_in,
    output logic            tx_ready_out
);
    // reply bytes as the terminal sees them, oldest first
    logic [7:0] got[$];
    logic       phase;

    initial begin
        tx_ready_out = 1'b0;
        phase = 1'b0;
    end

    // slow mode takes a byte every other cycle, hold stalls the link fully
    always @(negedge clk_in) begin
        phase <= !phase;
        tx_ready_out <= !hold_in && (!slow_in || phase);
    end

    always @(posedge clk_in) begin
        if (tx_valid_in && tx_ready_out) begin
            got.push_back(tx_data_in);
        end
    end
endmodule

//--- verif/tb.sv
`timescale 1ns/1ns
module tb;
    import can_cmd_pkg::*;
    localparam int HALF = 4;
    logic        clk_in, nrst_in, rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
    logic [7:0]  rx_data_in, tx_data_out;
    logic        frame_valid_out, frame_ready_in, frame_event_in, can_error_in;
    logic        power_led_out, act_led_out, err_led_out, hold, slow;
    can_frame_t  frame_out;
    chan_t       chan_out;
    logic [3:0]  bitrate_out;
    int          fails, n_tests;

    serial_can_command_led_ctrl #(.FLASH_HALF(HALF), .FIFO_DEPTH(16)) dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .rx_valid_in(rx_valid_in),
        .rx_ready_out(rx_ready_out), .rx_data_in(rx_data_in), .tx_valid_out(tx_valid_out),
        .tx_ready_in(tx_ready_in), .tx_data_out(tx_data_out),
        .frame_valid_out(frame_valid_out), .frame_ready_in(frame_ready_in),
        .frame_out(frame_out), .chan_out(chan_out), .bitrate_out(bitrate_out),
        .frame_event_in(frame_event_in), .can_error_in(can_error_in),
        .power_led_out(power_led_out), .act_led_out(act_led_out), .err_led_out(err_led_out));

    host_sink host (.clk_in(clk_in), .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
        .hold_in(hold), .slow_in(slow), .tx_ready_out(tx_ready_in));

    initial clk_in = 1'b0;
    always #25 clk_in = ~clk_in;

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // request held from a falling edge until a rising edge sees ready
    task send_byte(input logic [7:0] b);
        int i;
        bit ok;
        ok = 0;
        rx_data_in = b;
        rx_valid_in = 1'b1;
        for (i = 0; i < 400 && !ok; i++) begin
            ok = (rx_ready_out === 1'b1);
            @(negedge clk_in);
        end
        if (!ok) begin
            fails++;
            $display("Error at %0t: byte never taken", $time);
            give_verdict;
        end
    endtask

    task send_line(input string s);
        int i;
        for (i = 0; i < s.len(); i++) send_byte(s[i]);
        send_byte(CH_CR);
        rx_valid_in = 1'b0;
    endtask

    task expect_byte(input logic [7:0] b);
        int i;
        for (i = 0; i < 400 && host.got.size() == 0; i++) @(negedge clk_in);
        if (host.got.size() == 0) begin
            fails++;
            $display("Error at %0t: no reply", $time);
            give_verdict;
        end
        check(host.got.pop_front(), b, "reply byte");
    endtask

    task cmd(input string s, input logic [7:0] r);
        send_line(s);
        expect_byte(r);
    endtask

    // engine side stalls three cycles before accepting
    task take_frame(input logic [78:0] f);
        int i;
        for (i = 0; i < 100 && frame_valid_out !== 1'b1; i++) @(negedge clk_in);
        check(frame_valid_out, 1'b1, "frame request");
        repeat (3) @(negedge clk_in);
        check(frame_out, f, "frame contents");
        frame_ready_in = 1'b1;
        @(negedge clk_in);
        frame_ready_in = 1'b0;
        expect_byte(CH_ACK);
        expect_byte(CH_CR);
    endtask

    task t_init;
        int i, rises;
        logic prev;
        rises = 0;
        prev = 1'b0;
        check(rx_ready_out, 1'b0, "ready during init");
        for (i = 0; i < 200 && rx_ready_out !== 1'b1; i++) begin
            @(negedge clk_in);
            if (act_led_out !== err_led_out) check(err_led_out, act_led_out, "joint flash");
            if (act_led_out === 1'b1 && prev === 1'b0) rises++;
            prev = act_led_out;
        end
        check(rx_ready_out, 1'b1, "init finished");
        check(rises, 4, "init flashes");
        check(power_led_out, 1'b1, "power lamp");
        check(act_led_out, 1'b0, "closed lamp");
        $display("test init done");
    endtask

    task t_rate;
        cmd("S3", CH_CR);
        check(bitrate_out, 4'h3, "rate 3");
        cmd("S9", CH_BELL);
        check(bitrate_out, 4'h3, "rate kept");
        cmd("S6", CH_CR);
        check(bitrate_out, RATE_500K, "rate 500k");
        $display("test rate done");
    endtask

    task t_open;
        cmd("O", CH_CR);
        check(chan_out, 3'h4, "normal open");
        check(act_led_out, 1'b1, "open lamp");
        cmd("L", CH_BELL);
        cmd("S3", CH_BELL);
        check(bitrate_out, RATE_500K, "rate while open");
        $display("test open done");
    endtask

    task t_send;
        int i, n;
        logic prev, seen0;
        send_line("t0023112233");
        take_frame({11'h002, 4'h3, 8'h11, 8'h22, 8'h33, 40'h0});
        send_line("t7FF1aB");
        take_frame({11'h7FF, 4'h1, 8'hAB, 56'h0});
        frame_event_in = 1'b1;
        @(negedge clk_in);
        frame_event_in = 1'b0;
        seen0 = 1'b0;
        for (i = 0; i < 20; i++) begin
            @(negedge clk_in);
            if (act_led_out === 1'b0) seen0 = 1'b1;
        end
        check(seen0, 1'b1, "traffic flash");
        repeat (40) @(negedge clk_in);
        check(act_led_out, 1'b1, "steady after traffic");
        can_error_in = 1'b1;
        n = 0;
        prev = err_led_out;
        for (i = 0; i < 40; i++) begin
            @(negedge clk_in);
            if (err_led_out !== prev) n++;
            prev = err_led_out;
        end
        check(n >= 2, 1'b1, "error flash");
        can_error_in = 1'b0;
        repeat (10) @(negedge clk_in);
        check(err_led_out, 1'b0, "error lamp off");
        $display("test send done");
    endtask

    task t_close;
        cmd("C", CH_CR);
        check(chan_out, 3'h0, "closed");
        check(act_led_out, 1'b0, "closed lamp");
        cmd("C", CH_BELL);
        cmd("Q", CH_BELL);
        cmd("", CH_BELL);
        $display("test close done");
    endtask

    task t_modes;
        cmd("L", CH_CR);
        check(chan_out, 3'h6, "listen open");
        cmd("t0023112233", CH_BELL);
        check(frame_valid_out, 1'b0, "no frame in listen");
        cmd("C", CH_CR);
        cmd("Y", CH_CR);
        check(chan_out, 3'h5, "loopback open");
        send_line("t0000");
        take_frame({11'h000, 4'h0, 64'h0});
        cmd("C", CH_CR);
        $display("test modes done");
    endtask

    // a stalled terminal fills the reply queue until lines are refused
    task t_fifo;
        int i;
        logic seen;
        hold = 1'b1;
        for (i = 0; i < 17; i++) send_byte(CH_CR);
        seen = 1'b0;
        for (i = 0; i < 20; i++) begin
            if (rx_ready_out === 1'b1) seen = 1'b1;
            @(negedge clk_in);
        end
        check(seen, 1'b0, "refused when full");
        slow = 1'b1;
        hold = 1'b0;
        send_byte(CH_CR);
        rx_valid_in = 1'b0;
        for (i = 0; i < 18; i++) expect_byte(CH_BELL);
        check(tx_valid_out, 1'b0, "queue drained");
        slow = 1'b0;
        $display("test fifo done");
    endtask

    initial begin
        repeat (100000) @(posedge clk_in);
        fails++;
        $display("Error at %0t: run too long", $time);
        give_verdict;
    end

    initial begin
        fails = 0;
        n_tests = 0;
        nrst_in = 1'b0;
        rx_valid_in = 1'b0;
        rx_data_in = 8'h00;
        frame_ready_in = 1'b0;
        frame_event_in = 1'b0;
        can_error_in = 1'b0;
        hold = 1'b0;
        slow = 1'b0;
        repeat (3) @(negedge clk_in);
        check(bitrate_out, RATE_RESET, "reset rate");
        nrst_in = 1'b1;
        t_init;
        t_rate;
        t_open;
        t_send;
        t_close;
        t_modes;
        t_fifo;
        give_verdict;
    end
endmodule
